// *** dat_pkg.sv ***
// constants, codes and register map for the disk address translator
// assumes one 50 MHz clock and a classic wishbone slave bus
//
// Summary of operation
// RULE_01: self test result 01 no error, 02 register access, 03 buffer data
// RULE_02: code 04 buffer logic fault, 05 processor rom or ram; 06-ff unused
// RULE_03: the result code sits in the error register at index 1f1
// RULE_04: reset or the diagnose command runs the whole self test sequence; here it stops at the first failing check
// RULE_05: tests cover rom, ram, buffer and data paths, never the host bus
// RULE_06: set parameters with sector count 17 selects seventeen sector mode
// RULE_07: host programs logical heads as twice the physical heads, max 16
// RULE_08: sector 0 spare; 1-17 even logical head, 18-34 odd logical head
// RULE_09: format in seventeen sector mode writes data fields only, not ids
// RULE_10: general mode when physical cylinders exceed 1024; 63 spt, 16 heads
// RULE_11: absolute index is ((cyl*heads+head)*spt)+sector-1
// RULE_12: absolute head is index/34, sector remainder+1, head mod heads
// RULE_13: accept logical heads 0-15, cylinders 0-1023, sectors 1-63
// RULE_14: only read and write translate; format and others stay physical
// RULE_15: reverse map divides the physical index by logical spt and heads
// RULE_16: physical cylinder is absolute head divided by physical heads
// RULE_17: translation ends a fixed number of cycles after the command
package dat_pkg;
    // -------------------------------------------------------------
    // register indexes, byte address is four times the index
    // -------------------------------------------------------------
    localparam logic [9:0] IDX_ERR = 10'h1f1;
    localparam logic [9:0] IDX_SECCNT = 10'h1f2;
    localparam logic [9:0] IDX_SECNUM = 10'h1f3;
    localparam logic [9:0] IDX_CYL_LO = 10'h1f4;
    localparam logic [9:0] IDX_CYL_HI = 10'h1f5;
    localparam logic [9:0] IDX_SDH = 10'h1f6;
    localparam logic [9:0] IDX_CMD = 10'h1f7;
    localparam logic [9:0] IDX_GEOM_HEADS = 10'h180;
    localparam logic [9:0] IDX_GEOM_CYLS = 10'h181;
    localparam logic [9:0] IDX_OUT_CYL = 10'h182;
    localparam logic [9:0] IDX_OUT_HS = 10'h183;
    localparam logic [9:0] IDX_IRQ_ST = 10'h184;
    localparam logic [9:0] IDX_IRQ_CLR = 10'h185;
    localparam logic [9:0] IDX_IRQ_EN = 10'h186;
    // -------------------------------------------------------------
    // codes, commands and geometry
    // -------------------------------------------------------------
    localparam logic [7:0] CODE_OK = 8'h01;
    localparam logic [7:0] CODE_CTRL = 8'h02;
    localparam logic [7:0] CODE_BUF = 8'h03;
    localparam logic [7:0] CODE_BLOGIC = 8'h04;
    localparam logic [7:0] CODE_CPU = 8'h05;
    localparam logic [7:0] CMD_READ = 8'h20;
    localparam logic [7:0] CMD_WRITE = 8'h30;
    localparam logic [7:0] CMD_FORMAT = 8'h50;
    localparam logic [7:0] CMD_DIAG = 8'h90;
    localparam logic [7:0] CMD_SETP = 8'h91;
    localparam logic [7:0] CMD_REVERSE = 8'h9a;
    localparam logic [7:0] SPT_17 = 8'h11;
    localparam logic [7:0] LSPT_GEN = 8'h3f;
    localparam logic [7:0] LHDS_GEN = 8'h10;
    localparam logic [7:0] PHYSICAL_SECTORS_PER_TRACK = 8'h22;
    localparam logic [15:0] CYL_GEN_LIMIT = 16'h0400;
    localparam logic [15:0] LOGICAL_CYLINDER_MAX = 16'h03ff;
    localparam logic [4:0] PHEADS_RST = 5'h08;
    localparam logic [15:0] PCYLS_RST = 16'h0400;
    // status bits at the command index, interrupt bits
    localparam int ST_M17 = 0;
    localparam int ST_GEN = 1;
    localparam int ST_BUSY = 7;
    localparam int IRQ_W = 3;
    localparam int IRQ_TEST = 0;
    localparam int IRQ_XLAT = 1;
    localparam int IRQ_RANGE = 2;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_TEST = 3'b001,
        S_MUL = 3'b010,
        S_DIV = 3'b011,
        S_DONE = 3'b100
    } dat_state_t;

    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_READ = 2'b01,
        OP_WRITE = 2'b10,
        OP_FORMAT = 2'b11
    } dat_op_t;
endpackage

// *** dat_top.sv ***
// disk address translator with self test sequencer and wishbone slave
// assumes fault inputs come from logic on clk_i; one bus master
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/10ps
module dat_top #(
    parameter int AW = 26
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [11:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // self test check results, bit 0 rom/ram, 1 regs, 2 buffer data, 3 buffer logic
    input wire logic [3:0] fault_i,
    // drive side
    output logic [15:0] phys_cyl_o,
    output logic [3:0] phys_head_o,
    output logic [7:0] phys_sec_o,
    output logic [1:0] op_o,
    output logic data_only_o,
    output logic seek_o,
    // interrupt
    output logic irq_o
);
    localparam int CW = $clog2(AW + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(AW - 1);
    localparam logic [AW-1:0] ONE = AW'(1);
    localparam logic [1:0] STEP_LAST = 2'h3;

    typedef struct packed {
        dat_pkg::dat_state_t st;
        logic [1:0] step;
        logic [CW-1:0] cnt;
        logic ph;
        logic rev;
        dat_pkg::dat_op_t op;
        logic [AW-1:0] num;
        logic [7:0] den;
        logic [7:0] rem;
        logic [7:0] err;
        logic [7:0] seccnt;
        logic [7:0] secnum;
        logic [15:0] cyl;
        logic [7:0] drive_head_select_register;
        logic mode17;
        logic [4:0] lhds17;
        logic [4:0] pheads;
        logic [15:0] pcyls;
        logic [15:0] ocyl;
        logic [3:0] ohead;
        logic [7:0] osec;
        logic [dat_pkg::IRQ_W-1:0] ist;
        logic [dat_pkg::IRQ_W-1:0] ien;
        logic ack;
        logic [31:0] dat;
        logic seek;
        logic donly;
    } dat_reg_t;

    // reset lands in the test state so the self test runs at once
    localparam dat_reg_t RST_VAL = '{
        st: dat_pkg::S_TEST, // see RULE_04
        op: dat_pkg::OP_NONE,
        pheads: dat_pkg::PHEADS_RST,
        pcyls: dat_pkg::PCYLS_RST,
        default: '0
    };

    dat_reg_t q;
    dat_reg_t d;
    logic req;
    logic wr;
    logic go;
    logic gen;
    logic xlat;
    logic bad;
    logic ge;
    logic [9:0] idx;
    logic [7:0] lspt;
    logic [7:0] lhds;
    logic [8:0] trial;
    logic [7:0] rem_f;
    logic [AW-1:0] quo_f;
    logic [dat_pkg::IRQ_W-1:0] ev;
    logic [dat_pkg::IRQ_W-1:0] clr;

    always_comb begin
        d = q;
        d.seek = 1'b0;
        ev = '0;
        clr = '0;
        go = 1'b0;
        // -------------------------------------------------------------
        // mode selection
        // -------------------------------------------------------------
        gen = q.pcyls > dat_pkg::CYL_GEN_LIMIT; // see RULE_10
        lspt = q.mode17 ? dat_pkg::SPT_17 : dat_pkg::LSPT_GEN;
        lhds = q.mode17 ? {3'h0, q.lhds17} : dat_pkg::LHDS_GEN;
        xlat = q.mode17 | gen;
        bad = (q.cyl > dat_pkg::LOGICAL_CYLINDER_MAX) | (q.secnum == 8'h00)
            | (q.secnum > lspt); // see RULE_13
        // -------------------------------------------------------------
        // wishbone slave, answer one cycle after the request
        // -------------------------------------------------------------
        req = cyc_i & stb_i & ~q.ack;
        wr = req & we_i & sel_i[0];
        idx = adr_i[11:2];
        d.ack = req;
        if (req) begin
            d.dat = '0;
            unique case (idx)
                dat_pkg::IDX_ERR: d.dat[7:0] = q.err; // see RULE_03
                dat_pkg::IDX_SECCNT: d.dat[7:0] = q.seccnt;
                dat_pkg::IDX_SECNUM: d.dat[7:0] = q.secnum;
                dat_pkg::IDX_CYL_LO: d.dat[7:0] = q.cyl[7:0];
                dat_pkg::IDX_CYL_HI: d.dat[7:0] = q.cyl[15:8];
                dat_pkg::IDX_SDH: d.dat[7:0] = q.drive_head_select_register;
                dat_pkg::IDX_CMD: begin
                    d.dat[dat_pkg::ST_M17] = q.mode17;
                    d.dat[dat_pkg::ST_GEN] = gen;
                    d.dat[dat_pkg::ST_BUSY] = q.st != dat_pkg::S_IDLE;
                end
                dat_pkg::IDX_GEOM_HEADS: d.dat[4:0] = q.pheads;
                dat_pkg::IDX_GEOM_CYLS: d.dat[15:0] = q.pcyls;
                dat_pkg::IDX_OUT_CYL: d.dat[15:0] = q.ocyl;
                dat_pkg::IDX_OUT_HS: d.dat[11:0] = {q.ohead, q.osec};
                dat_pkg::IDX_IRQ_ST: d.dat[dat_pkg::IRQ_W-1:0] = q.ist;
                dat_pkg::IDX_IRQ_EN: d.dat[dat_pkg::IRQ_W-1:0] = q.ien;
                default: d.dat = '0;
            endcase
        end
        if (wr) begin
            unique case (idx)
                dat_pkg::IDX_SECCNT: d.seccnt = dat_i[7:0];
                dat_pkg::IDX_SECNUM: d.secnum = dat_i[7:0];
                dat_pkg::IDX_CYL_LO: d.cyl[7:0] = dat_i[7:0];
                dat_pkg::IDX_CYL_HI: d.cyl[15:8] = dat_i[7:0];
                dat_pkg::IDX_SDH: d.drive_head_select_register = dat_i[7:0];
                dat_pkg::IDX_CMD: go = 1'b1;
                dat_pkg::IDX_GEOM_HEADS: d.pheads = dat_i[4:0];
                dat_pkg::IDX_GEOM_CYLS: d.pcyls = dat_i[15:0];
                dat_pkg::IDX_IRQ_CLR: clr = dat_i[dat_pkg::IRQ_W-1:0];
                dat_pkg::IDX_IRQ_EN: d.ien = dat_i[dat_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
        // -------------------------------------------------------------
        // divider step, shared by both divisions
        // -------------------------------------------------------------
        trial = {q.rem, q.num[AW-1]};
        ge = trial >= {1'b0, q.den};
        rem_f = ge ? 8'(trial - {1'b0, q.den}) : trial[7:0];
        quo_f = {q.num[AW-2:0], ge};
        // -------------------------------------------------------------
        // sequencer
        // -------------------------------------------------------------
        unique case (q.st)
            dat_pkg::S_IDLE: begin
                // commands arriving while busy are dropped
                if (go) begin
                    unique case (dat_i[7:0])
                        dat_pkg::CMD_DIAG: begin
                            d.st = dat_pkg::S_TEST; // see RULE_04
                            d.step = '0;
                        end
                        dat_pkg::CMD_SETP: begin
                            d.mode17 = q.seccnt == dat_pkg::SPT_17; // see RULE_06
                            // head field holds one less than twice the physical heads
                            d.lhds17 = 5'(q.drive_head_select_register[3:0]) + 5'h01; // see RULE_07
                        end
                        dat_pkg::CMD_READ, dat_pkg::CMD_WRITE: begin
                            d.op = (dat_i[7:0] == dat_pkg::CMD_READ) ?
                                dat_pkg::OP_READ : dat_pkg::OP_WRITE;
                            d.donly = 1'b0;
                            d.rev = 1'b0;
                            if (xlat && bad) begin
                                ev[dat_pkg::IRQ_RANGE] = 1'b1; // see RULE_13
                            end else if (xlat) begin
                                d.st = dat_pkg::S_MUL; // see RULE_14
                            end else begin
                                d.ocyl = q.cyl;
                                d.ohead = q.drive_head_select_register[3:0];
                                d.osec = q.secnum;
                                d.st = dat_pkg::S_DONE;
                            end
                        end
                        dat_pkg::CMD_FORMAT: begin
                            // format always addresses the drive physically
                            d.op = dat_pkg::OP_FORMAT; // see RULE_14
                            d.donly = q.mode17; // see RULE_09
                            d.rev = 1'b0;
                            d.ocyl = q.cyl;
                            d.ohead = q.drive_head_select_register[3:0];
                            d.osec = q.secnum;
                            d.st = dat_pkg::S_DONE;
                        end
                        dat_pkg::CMD_REVERSE: begin
                            d.rev = 1'b1;
                            d.st = dat_pkg::S_MUL;
                        end
                        default: ;
                    endcase
                end
            end
            dat_pkg::S_TEST: begin
                // checks walk in order, first fault found is reported
                if (fault_i[q.step]) begin // see RULE_05
                    unique case (q.step)
                        2'h0: d.err = dat_pkg::CODE_CPU; // see RULE_02
                        2'h1: d.err = dat_pkg::CODE_CTRL; // see RULE_01
                        2'h2: d.err = dat_pkg::CODE_BUF; // see RULE_01
                        2'h3: d.err = dat_pkg::CODE_BLOGIC; // see RULE_02
                    endcase
                    d.st = dat_pkg::S_IDLE;
                    ev[dat_pkg::IRQ_TEST] = 1'b1;
                end else if (q.step == STEP_LAST) begin
                    d.err = dat_pkg::CODE_OK; // see RULE_01
                    d.st = dat_pkg::S_IDLE;
                    ev[dat_pkg::IRQ_TEST] = 1'b1;
                end else begin
                    d.step = q.step + 2'h1;
                end
            end
            dat_pkg::S_MUL: begin
                // mode 17 folds the odd logical head into sectors 18-34
                if (q.rev) begin
                    d.num = ((AW'(q.cyl) * AW'(q.pheads) + AW'(q.drive_head_select_register[3:0]))
                        * AW'(dat_pkg::PHYSICAL_SECTORS_PER_TRACK)) + AW'(q.secnum); // see RULE_15
                    d.den = lspt;
                end else begin
                    d.num = ((AW'(q.cyl) * AW'(lhds) + AW'(q.drive_head_select_register[3:0]))
                        * AW'(lspt)) + AW'(q.secnum) - ONE; // see RULE_11
                    d.den = dat_pkg::PHYSICAL_SECTORS_PER_TRACK; // see RULE_08
                end
                d.rem = '0;
                d.cnt = '0;
                d.ph = 1'b0;
                d.st = dat_pkg::S_DIV;
            end
            dat_pkg::S_DIV: begin
                // fixed length: two divisions of AW steps each
                d.rem = rem_f;
                d.num = quo_f;
                d.cnt = q.cnt + 1'b1; // see RULE_17
                if (q.cnt == CNT_LAST) begin
                    d.cnt = '0;
                    d.rem = '0;
                    if (!q.ph) begin
                        d.osec = q.rev ? rem_f : rem_f + 8'h01; // see RULE_12
                        d.ph = 1'b1;
                        d.den = q.rev ? lhds : {3'h0, q.pheads};
                    end else begin
                        d.ohead = rem_f[3:0]; // see RULE_12
                        d.ocyl = quo_f[15:0]; // see RULE_16
                        d.st = dat_pkg::S_DONE;
                    end
                end
            end
            dat_pkg::S_DONE: begin
                // reverse lookups raise no seek, though the drive address outputs show the result
                d.seek = ~q.rev;
                ev[dat_pkg::IRQ_XLAT] = 1'b1;
                d.st = dat_pkg::S_IDLE;
            end
            default: d.st = dat_pkg::S_IDLE;
        endcase
        // a new event outranks a clear in the same cycle
        d.ist = (q.ist & ~clr) | ev;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= RST_VAL;
        end else begin
            q <= d;
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    assign dat_o = q.dat;
    assign ack_o = q.ack;
    assign phys_cyl_o = q.ocyl;
    assign phys_head_o = q.ohead;
    assign phys_sec_o = q.osec;
    assign op_o = q.op;
    assign data_only_o = q.donly;
    assign seek_o = q.seek;
    assign irq_o = |(q.ist & q.ien);
endmodule // dat_top

// *** dat_monitor.sv ***
// concurrent checks on the translator ports
// assumes one clock and a synchronous active high reset
`timescale 1ns/10ps
module dat_monitor (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [11:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // drive side
    input wire logic [15:0] phys_cyl_o,
    input wire logic [3:0] phys_head_o,
    input wire logic [7:0] phys_sec_o,
    input wire logic [1:0] op_o,
    input wire logic data_only_o,
    input wire logic seek_o,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // ----------------------------------------
    // sequences
    // ----------------------------------------
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_ack;
        ack_o ##1 !ack_o;
    endsequence
    sequence s_err_rd;
        s_req ##0 (!we_i && adr_i[11:2] == dat_pkg::IDX_ERR);
    endsequence
    sequence s_cmd;
        s_req ##0 (we_i && adr_i[11:2] == dat_pkg::IDX_CMD);
    endsequence
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    chk_ack_once: assert property (s_req |=> s_ack)
        else $error("ack not a single cycle after request");
    chk_err_code: assert property (s_err_rd |=> dat_o <= 32'h05)
        else $error("error register holds an undefined code");
    chk_seek_pulse: assert property (seek_o |=> !seek_o)
        else $error("seek longer than one cycle");
    chk_cmd_gap: assert property (s_cmd |=> !seek_o)
        else $error("seek too soon after command");
    chk_seek_op: assert property (seek_o |-> op_o != dat_pkg::OP_NONE)
        else $error("seek without an operation");
    chk_data_only: assert property (data_only_o |-> op_o == dat_pkg::OP_FORMAT)
        else $error("data only outside format");
    // reverse lookups move the address with no seek at all
    chk_addr_seek: assert property (
        seek_o |-> $stable({phys_cyl_o, phys_head_o, phys_sec_o}))
        else $error("drive address moved with the seek");
    // reset values must show even while reset is held
    chk_reset_quiet: assert property (disable iff (1'b0)
        rst_i |=> !ack_o && !seek_o && !irq_o && op_o == 2'h0)
        else $error("outputs active after reset");
endmodule // dat_monitor

bind dat_top dat_monitor u_dat_monitor (.clk_i, .rst_i, .cyc_i, .stb_i,
    .we_i, .adr_i, .dat_i, .dat_o, .ack_o, .phys_cyl_o, .phys_head_o,
    .phys_sec_o, .op_o, .data_only_o, .seek_o, .irq_o);

// *** dat_host.sv ***
// host model: classic wishbone master issuing register cycles
// assumes a slave that acks every request, mapped or not
`timescale 1ns/10ps
module dat_host (
    // clock and slave answer
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [31:0] rdat_i,
    // request
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [11:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] wdat_o
);
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 12'h000;
        sel_o = 4'h0;
        wdat_o = 32'h0;
    end
    // idle address and data are scrambled so nothing leans on old values
    task automatic xfer(input logic w, input logic [9:0] idx,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= {idx, 2'b00};
        sel_o <= 4'hf;
        wdat_o <= d;
        // hold the request until ack is seen at a rising edge, take data there
        do @(posedge clk_i); while (ack_i !== 1'b1);
        q = rdat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o <= 1'b0;
        sel_o <= 4'h0;
        adr_o <= ~adr_o;
        wdat_o <= ~wdat_o;
    endtask
    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, idx, d, q);
    endtask
    task automatic rd(input logic [9:0] idx, output logic [31:0] q);
        xfer(1'b0, idx, 32'h0, q);
    endtask
endmodule // dat_host

// *** dat_top_tb.sv ***
// bench for the translator: register calls through the host model
// assumes default divider width and physical heads left at reset 8
`timescale 1ns/10ps
module dat_top_tb;
    logic clk_i;
    logic rst_i = 1'b1;
    logic cyc_i, stb_i, we_i, ack_o, data_only_o, seek_o, irq_o;
    logic [11:0] adr_i;
    logic [3:0] sel_i, phys_head_o;
    logic [3:0] fault_i = 4'h0;
    logic [31:0] dat_i, dat_o, rv;
    logic [15:0] phys_cyl_o;
    logic [7:0] phys_sec_o;
    logic [1:0] op_o;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;
    logic [7:0] diag_exp [4] = '{8'h05, 8'h02, 8'h03, 8'h04};
    int rc [3] = '{0, 0, 1024};
    int rs [3] = '{0, 64, 1};
    int mh [3] = '{0, 0, 1};
    int ms [3] = '{1, 17, 1};
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    dat_host u_dat_host (.clk_i, .ack_i(ack_o), .rdat_i(dat_o), .cyc_o(cyc_i),
        .stb_o(stb_i), .we_o(we_i), .adr_o(adr_i), .sel_o(sel_i),
        .wdat_o(dat_i));
    dat_top u_dat_top (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
        .dat_i, .dat_o, .ack_o, .fault_i, .phys_cyl_o, .phys_head_o,
        .phys_sec_o, .op_o, .data_only_o, .seek_o, .irq_o);
    // hang guard, run needs well under 3000 cycles
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            err_total++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("compares %0d errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp);
        u_dat_host.rd(idx, rv);
        chk($sformatf("reg %h", idx), rv, exp);
    endtask
    task automatic cmd(input logic [7:0] c, input int gap);
        u_dat_host.wr(dat_pkg::IDX_CMD, {24'h0, c});
        repeat (gap) @(posedge clk_i);
    endtask
    task automatic addr(input int c, h, s);
        u_dat_host.wr(dat_pkg::IDX_CYL_LO, 32'(c % 256));
        u_dat_host.wr(dat_pkg::IDX_CYL_HI, 32'(c / 256));
        u_dat_host.wr(dat_pkg::IDX_SDH, 32'(h));
        u_dat_host.wr(dat_pkg::IDX_SECNUM, 32'(s));
    endtask
    function automatic logic [27:0] fwd(int c, h, s, lh, ls);
        int a;
        int ah;
        a = ((c * lh + h) * ls) + s - 1;
        ah = a / 34;
        return {16'(ah / 8), 4'(ah % 8), 8'(a % 34 + 1)};
    endfunction
    // waits for the seek pulse, then compares address and operation
    task automatic xl(input int c, h, s, input logic [7:0] op,
                      input logic [27:0] exp, input logic [1:0] eop);
        logic sk;
        addr(c, h, s);
        cmd(op, 0);
        sk = 1'b0;
        for (int i = 0; i < 80 && !sk; i++) begin
            @(negedge clk_i);
            sk = (seek_o === 1'b1);
        end
        chk("seek", sk, 1'b1);
        chk("phys", {phys_cyl_o, phys_head_o, phys_sec_o}, exp);
        chk("op", op_o, eop);
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        rdchk(dat_pkg::IDX_ERR, 32'h01);
        rdchk(dat_pkg::IDX_GEOM_HEADS, 32'h08);
        u_dat_host.wr(dat_pkg::IDX_ERR, 32'haa);
        rdchk(dat_pkg::IDX_ERR, 32'h01);
        rdchk(10'h3ff, 32'h0);
        u_dat_host.wr(dat_pkg::IDX_IRQ_EN, 32'h7);
        repeat (2) @(negedge clk_i);
        chk("irq raised", irq_o, 1'b1);
        u_dat_host.wr(dat_pkg::IDX_IRQ_CLR, 32'h1);
        repeat (2) @(negedge clk_i);
        chk("irq cleared", irq_o, 1'b0);
        for (int k = 0; k < 5; k++) begin
            fault_i <= (k < 4) ? 4'(1 << k) : 4'h0;
            cmd(dat_pkg::CMD_DIAG, 10);
            rdchk(dat_pkg::IDX_ERR, (k < 4) ? diag_exp[k] : 8'h01);
        end
        u_dat_host.wr(dat_pkg::IDX_IRQ_EN, 32'h0);
        repeat (2) @(negedge clk_i);
        chk("irq masked", irq_o, 1'b0);
        u_dat_host.wr(dat_pkg::IDX_GEOM_CYLS, 32'h401);
        rdchk(dat_pkg::IDX_CMD, 32'h02);
        xl(5, 3, 10, dat_pkg::CMD_READ, fwd(5, 3, 10, 16, 63), 2'h1);
        xl(1023, 15, 63, dat_pkg::CMD_WRITE, fwd(1023, 15, 63, 16, 63),
           2'h2);
        for (int k = 0; k < 3; k++) begin
            u_dat_host.wr(dat_pkg::IDX_IRQ_CLR, 32'h7);
            addr(rc[k], 0, rs[k]);
            cmd(dat_pkg::CMD_READ, 3);
            rdchk(dat_pkg::IDX_IRQ_ST, 32'h4);
        end
        addr(19, 2, 3);
        cmd(dat_pkg::CMD_REVERSE, 0);
        rdchk(dat_pkg::IDX_CMD, 32'h82);
        repeat (56) @(posedge clk_i);
        rdchk(dat_pkg::IDX_OUT_CYL, 32'h5);
        rdchk(dat_pkg::IDX_OUT_HS, 32'h30a);
        xl(7, 4, 9, dat_pkg::CMD_FORMAT, {16'h7, 4'h4, 8'h9}, 2'h3);
        chk("data only", data_only_o, 1'b0);
        u_dat_host.wr(dat_pkg::IDX_GEOM_CYLS, 32'h400);
        u_dat_host.wr(dat_pkg::IDX_SECCNT, 32'h11);
        addr(0, 15, 0);
        cmd(dat_pkg::CMD_SETP, 4);
        rdchk(dat_pkg::IDX_CMD, 32'h01);
        for (int k = 0; k < 3; k++) begin
            xl(2, mh[k], ms[k], dat_pkg::CMD_READ, fwd(2, mh[k], ms[k], 16, 17),
               2'h1);
        end
        xl(3, 1, 1, dat_pkg::CMD_FORMAT, {16'h3, 4'h1, 8'h1}, 2'h3);
        chk("data only", data_only_o, 1'b1);
        stop_test();
    end
endmodule // dat_top_tb
